// *** rtl/alt_limits.sv ***
// Functional notes
// - negative shunt high threshold trips on a zero shunt sample.
// - shunt high threshold is signed 16-bit, scaled by shunt range.
// - shunt low threshold is signed 16-bit, flags samples below it.
// - bus high threshold is unsigned 15-bit, flags bus overvoltage.
// - bus low threshold is unsigned 15-bit, flags bus undervoltage.
// - bit 15 of both bus thresholds ignores writes, reads zero.
// - temperature threshold in bits 15:4, signed, compared with die temp.
// - low four temperature threshold bits always read zero.
// - power threshold unsigned, 256 power steps per code, flags over-power.
// - fixed read-only 16-bit maker code register.
// - shunt thresholds reset to most positive and most negative codes.
// - each comparison sets its own limit flag on a crossing.
// - latched flags hold until diagnostic read; transparent ones follow.
// - shunt range select picks the LSB weight of shunt codes.
module alt_limits
	import alt_pkg::*;
#(
	// arbitrary neutral value, not any real maker
	parameter logic [15:0] MAKER_CODE = 16'h4142
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// register access
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_rd,
	output logic      [DATA_W-1:0]   reg_rdata,
	// configuration and diagnostic access
	input  wire logic                shunt_range_select,
	input  wire logic                alert_latch_select,
	input  wire logic                diag_read,
	// shunt result
	input  wire logic [DATA_W-1:0]   shunt_result,
	input  wire logic                shunt_valid,
	// bus result
	input  wire logic [DATA_W-1:0]   bus_result,
	input  wire logic                bus_valid,
	// temperature result
	input  wire logic [TEMP_W-1:0]   die_temperature_result,
	input  wire logic                temp_valid,
	// power result
	input  wire logic [POWER_W-1:0]  power_result,
	input  wire logic                power_valid,
	// limit status
	output logic      [NUM_FLAGS-1:0] limit_flags,
	output logic                     limit_alert
);

	// threshold storage
	logic [DATA_W-1:0]    shunt_hi_ff;
	logic [DATA_W-1:0]    shunt_lo_ff;
	logic [BUS_THR_W-1:0] bus_hi_ff;
	logic [BUS_THR_W-1:0] bus_lo_ff;
	logic [TEMP_W-1:0]    temp_hi_ff;
	logic [DATA_W-1:0]    power_hi_ff;
	logic [DATA_W-1:0]    nxt_shunt_hi;
	logic [DATA_W-1:0]    nxt_shunt_lo;
	logic [BUS_THR_W-1:0] nxt_bus_hi;
	logic [BUS_THR_W-1:0] nxt_bus_lo;
	logic [TEMP_W-1:0]    nxt_temp_hi;
	logic [DATA_W-1:0]    nxt_power_hi;

	// read path and status
	logic [DATA_W-1:0]    rd_val;
	logic [DATA_W-1:0]    reg_rdata_ff;
	logic [DATA_W-1:0]    nxt_rdata;
	logic                 range_ff;
	logic                 nxt_range;
	logic                 range_chg;
	logic                 alert_ff;
	logic                 nxt_alert;

	// comparison levels
	logic                 shunt_over;
	logic                 shunt_under;
	logic                 bus_over;
	logic                 bus_under;
	logic                 temp_over;
	logic                 power_over;
	logic [NUM_FLAGS-1:0] conds;
	logic [NUM_FLAGS-1:0] flags;

	always_comb begin
		nxt_shunt_hi = shunt_hi_ff;
		nxt_shunt_lo = shunt_lo_ff;
		nxt_bus_hi   = bus_hi_ff;
		nxt_bus_lo   = bus_lo_ff;
		nxt_temp_hi  = temp_hi_ff;
		nxt_power_hi = power_hi_ff;
		if (reg_wr) begin
			case (reg_addr)
				SHUNT_HI_OFS: nxt_shunt_hi = reg_wdata;
				SHUNT_LO_OFS: nxt_shunt_lo = reg_wdata;
				// bit 15 of the bus words is dropped
				BUS_HI_OFS: nxt_bus_hi = reg_wdata[BUS_THR_W-1:0];
				BUS_LO_OFS: nxt_bus_lo = reg_wdata[BUS_THR_W-1:0];
				TEMP_HI_OFS: nxt_temp_hi = reg_wdata[DATA_W-1:TEMP_LSB];
				POWER_HI_OFS: nxt_power_hi = reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shunt_hi_ff <= SHUNT_HI_RST;
			shunt_lo_ff <= SHUNT_LO_RST;
			bus_hi_ff   <= BUS_HI_RST[BUS_THR_W-1:0];
			bus_lo_ff   <= BUS_LO_RST[BUS_THR_W-1:0];
			temp_hi_ff  <= TEMP_HI_RST[DATA_W-1:TEMP_LSB];
			power_hi_ff <= POWER_HI_RST;
		end else begin
			shunt_hi_ff <= nxt_shunt_hi;
			shunt_lo_ff <= nxt_shunt_lo;
			bus_hi_ff   <= nxt_bus_hi;
			bus_lo_ff   <= nxt_bus_lo;
			temp_hi_ff  <= nxt_temp_hi;
			power_hi_ff <= nxt_power_hi;
		end
	end

	always_comb begin
		case (reg_addr)
			SHUNT_HI_OFS: rd_val = shunt_hi_ff;
			SHUNT_LO_OFS: rd_val = shunt_lo_ff;
			BUS_HI_OFS:   rd_val = {1'b0, bus_hi_ff};
			BUS_LO_OFS:   rd_val = {1'b0, bus_lo_ff};
			TEMP_HI_OFS:  rd_val = {temp_hi_ff, 4'h0};
			POWER_HI_OFS: rd_val = power_hi_ff;
			MAKER_OFS:    rd_val = MAKER_CODE;
			// offsets outside this bank read zero
			default:      rd_val = 16'h0000;
		endcase
	end

	// a stored shunt level was coded in the old range, so drop it
	assign range_chg = shunt_range_select != range_ff;

	always_comb begin
		nxt_rdata = reg_rd ? rd_val : reg_rdata_ff;
		nxt_range = shunt_range_select;
		nxt_alert = |flags;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= RDATA_RST;
			range_ff     <= 1'b0;
			alert_ff     <= 1'b0;
		end else begin
			reg_rdata_ff <= nxt_rdata;
			range_ff     <= nxt_range;
			alert_ff     <= nxt_alert;
		end
	end

	// shunt codes and thresholds share one LSB, so raw codes compare
	alt_cmp #(
		.W      (DATA_W),
		.SIGNED (1'b1)
	) u_shunt_cmp (
		.clk          (clk),
		.rst          (rst),
		.flush        (range_chg),
		.sample_valid (shunt_valid),
		.sample       (shunt_result),
		.high_thr     (shunt_hi_ff),
		.low_thr      (shunt_lo_ff),
		.over         (shunt_over),
		.under        (shunt_under)
	);

	alt_cmp #(
		.W      (DATA_W),
		.SIGNED (1'b0)
	) u_bus_cmp (
		.clk          (clk),
		.rst          (rst),
		.flush        (1'b0),
		.sample_valid (bus_valid),
		.sample       (bus_result),
		.high_thr     ({1'b0, bus_hi_ff}),
		.low_thr      ({1'b0, bus_lo_ff}),
		.over         (bus_over),
		.under        (bus_under)
	);

	alt_cmp #(
		.W      (TEMP_W),
		.SIGNED (1'b1)
	) u_temp_cmp (
		.clk          (clk),
		.rst          (rst),
		.flush        (1'b0),
		.sample_valid (temp_valid),
		.sample       (die_temperature_result),
		.high_thr     (temp_hi_ff),
		.low_thr      ({TEMP_W{1'b0}}),
		.over         (temp_over),
		.under        ()
	);

	alt_cmp #(
		.W      (POWER_W),
		.SIGNED (1'b0)
	) u_power_cmp (
		.clk          (clk),
		.rst          (rst),
		.flush        (1'b0),
		.sample_valid (power_valid),
		.sample       (power_result),
		.high_thr     ({power_hi_ff, {POWER_SHIFT{1'b0}}}),
		.low_thr      ({POWER_W{1'b0}}),
		.over         (power_over),
		.under        ()
	);

	always_comb begin
		conds               = '0;
		conds[FLG_TEMP_HI]  = temp_over;
		conds[FLG_SHUNT_HI] = shunt_over;
		conds[FLG_SHUNT_LO] = shunt_under;
		conds[FLG_BUS_HI]   = bus_over;
		conds[FLG_BUS_LO]   = bus_under;
		conds[FLG_POWER_HI] = power_over;
	end

	for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
		alt_flag u_flag (
			.clk     (clk),
			.rst     (rst),
			.latched (alert_latch_select),
			.clear   (diag_read),
			.cond    (conds[i]),
			.flag    (flags[i])
		);
	end

	assign limit_flags = flags;
	assign limit_alert = alert_ff;
	assign reg_rdata   = reg_rdata_ff;

	// checks

	sequence s_shunt_take;
		shunt_valid && !range_chg;
	endsequence

	shunt_zero_a: assert property (
		@(posedge clk) disable iff (rst)
		s_shunt_take ##0 (shunt_result == 16'h0000 && shunt_hi_ff[15])
		|=> shunt_over)
		else $error("zero shunt missed a negative high threshold");
	shunt_over_a: assert property (
		@(posedge clk) disable iff (rst)
		s_shunt_take |=> shunt_over ==
			($signed($past(shunt_result)) > $signed($past(shunt_hi_ff))))
		else $error("shunt over compare wrong");
	shunt_under_a: assert property (
		@(posedge clk) disable iff (rst)
		s_shunt_take |=> shunt_under ==
			($signed($past(shunt_result)) < $signed($past(shunt_lo_ff))))
		else $error("shunt under compare wrong");
	bus_over_a: assert property (
		@(posedge clk) disable iff (rst)
		bus_valid |=> bus_over ==
			($past(bus_result) > {1'b0, $past(bus_hi_ff)}))
		else $error("bus over compare wrong");
	bus_under_a: assert property (
		@(posedge clk) disable iff (rst)
		bus_valid |=> bus_under ==
			($past(bus_result) < {1'b0, $past(bus_lo_ff)}))
		else $error("bus under compare wrong");
	bus_rsvd_a: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && (reg_addr == BUS_HI_OFS || reg_addr == BUS_LO_OFS)
		|=> reg_rdata_ff[15] == 1'b0)
		else $error("bus reserved bit read nonzero");
	temp_over_a: assert property (
		@(posedge clk) disable iff (rst)
		temp_valid |=> temp_over ==
			($signed($past(die_temperature_result)) >
			 $signed($past(temp_hi_ff))))
		else $error("temperature compare wrong");
	temp_rsvd_a: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == TEMP_HI_OFS |=> reg_rdata_ff[3:0] == 4'h0)
		else $error("temperature reserved bits read nonzero");
	power_over_a: assert property (
		@(posedge clk) disable iff (rst)
		power_valid |=> power_over ==
			($past(power_result) > {$past(power_hi_ff), 8'h00}))
		else $error("power compare wrong");
	maker_code_a: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == MAKER_OFS ##1 !reg_rd
		|=> reg_rdata_ff == MAKER_CODE && $stable(reg_rdata_ff))
		else $error("maker code read wrong");
	reset_vals_a: assert property (
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> shunt_hi_ff == SHUNT_HI_RST &&
			shunt_lo_ff == SHUNT_LO_RST)
		else $error("shunt thresholds not at reset values");
	range_flush_a: assert property (
		@(posedge clk) disable iff (rst)
		range_chg |=> !shunt_over && !shunt_under)
		else $error("shunt level survived range change");
	alert_or_a: assert property (
		@(posedge clk) disable iff (rst)
		|flags |=> limit_alert)
		else $error("alert missing with a flag set");

endmodule // alt_limits

// *** rtl/alt_pkg.sv ***
package alt_pkg;

	// register access port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [7:0] SHUNT_HI_OFS = 8'h0C;
	localparam logic [7:0] SHUNT_LO_OFS = 8'h0D;
	localparam logic [7:0] BUS_HI_OFS   = 8'h0E;
	localparam logic [7:0] BUS_LO_OFS   = 8'h0F;
	localparam logic [7:0] TEMP_HI_OFS  = 8'h10;
	localparam logic [7:0] POWER_HI_OFS = 8'h11;
	localparam logic [7:0] MAKER_OFS    = 8'h3E;

	// values after reset
	localparam logic [15:0] SHUNT_HI_RST = 16'h7FFF;
	localparam logic [15:0] SHUNT_LO_RST = 16'h8000;
	localparam logic [15:0] BUS_HI_RST   = 16'h7FFF;
	localparam logic [15:0] BUS_LO_RST   = 16'h0000;
	localparam logic [15:0] TEMP_HI_RST  = 16'h7FFF;
	localparam logic [15:0] POWER_HI_RST = 16'h0FFF;
	localparam logic [15:0] RDATA_RST    = 16'h0000;

	// field layout
	localparam int BUS_THR_W   = 15;
	localparam int TEMP_LSB    = 4;
	localparam int TEMP_W      = 12;
	localparam int POWER_W     = 24;
	localparam int POWER_SHIFT = 8;

	// flag positions in limit_flags
	localparam int FLG_TEMP_HI  = 5;
	localparam int FLG_SHUNT_HI = 4;
	localparam int FLG_SHUNT_LO = 3;
	localparam int FLG_BUS_HI   = 2;
	localparam int FLG_BUS_LO   = 1;
	localparam int FLG_POWER_HI = 0;
	localparam int NUM_FLAGS    = 6;

endpackage

// *** rtl/alt_cmp.sv ***
module alt_cmp
	import alt_pkg::*;
#(
	parameter int   W      = 16,
	parameter logic SIGNED = 1'b1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// sample and thresholds
	input  wire logic         flush,
	input  wire logic         sample_valid,
	input  wire logic [W-1:0] sample,
	input  wire logic [W-1:0] high_thr,
	input  wire logic [W-1:0] low_thr,
	// comparison levels
	output logic              over,
	output logic              under
);

	// flipping the sign bit lets one unsigned compare serve both codings
	localparam logic [W-1:0] BIAS = SIGNED ? {1'b1, {(W-1){1'b0}}} : '0;

	logic [W-1:0] s_b;
	logic [W-1:0] hi_b;
	logic [W-1:0] lo_b;
	logic         over_ff;
	logic         under_ff;
	logic         nxt_over;
	logic         nxt_under;

	assign s_b  = sample ^ BIAS;
	assign hi_b = high_thr ^ BIAS;
	assign lo_b = low_thr ^ BIAS;

	always_comb begin
		nxt_over  = over_ff;
		nxt_under = under_ff;
		if (flush) begin
			nxt_over  = 1'b0;
			nxt_under = 1'b0;
		end else if (sample_valid) begin
			nxt_over  = s_b > hi_b;
			nxt_under = s_b < lo_b;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			over_ff  <= 1'b0;
			under_ff <= 1'b0;
		end else begin
			over_ff  <= nxt_over;
			under_ff <= nxt_under;
		end
	end

	assign over  = over_ff;
	assign under = under_ff;

	property p_fresh;
		@(posedge clk) disable iff (rst)
		sample_valid && !flush |=>
			over_ff == ($past(s_b) > $past(hi_b)) &&
			under_ff == ($past(s_b) < $past(lo_b));
	endproperty
	fresh_result_a: assert property (p_fresh)
		else $error("comparison not taken from new sample");

endmodule // alt_cmp

// *** rtl/alt_flag.sv ***
module alt_flag
	import alt_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic latched,
	input  wire logic clear,
	input  wire logic cond,
	// flag
	output logic      flag
);

	logic flag_ff;
	logic nxt_flag;

	always_comb begin
		if (!latched) begin
			nxt_flag = cond;
		end else if (cond) begin
			nxt_flag = 1'b1;
		end else if (clear) begin
			nxt_flag = 1'b0;
		end else begin
			nxt_flag = flag_ff;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

	sequence s_held_fault;
		latched && flag_ff && !cond && !clear;
	endsequence

	sequence s_read_clean;
		latched && clear && !cond;
	endsequence

	flag_set_a: assert property (
		@(posedge clk) disable iff (rst) cond |=> flag_ff)
		else $error("limit flag missed its fault");
	latch_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		s_held_fault ##1 (latched && !cond && !clear) |=> flag_ff)
		else $error("latched flag dropped without a read");
	latch_clear_a: assert property (
		@(posedge clk) disable iff (rst) s_read_clean |=> !flag_ff)
		else $error("latched flag survived a read");
	transp_follow_a: assert property (
		@(posedge clk) disable iff (rst)
		!latched |=> flag_ff == $past(cond))
		else $error("transparent flag not following fault");

endmodule // alt_flag

// *** testbench/alt_host.sv ***
module alt_host
	import alt_pkg::*;
(
	// clock
	input  wire logic              clk,
	// register access
	output logic      [ADDR_W-1:0] reg_addr,
	output logic                   reg_wr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		{reg_wr, reg_rd} = 2'b00;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		// released data shows no stale word
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule // alt_host

// *** testbench/alt_limits_tb.sv ***
module alt_limits_tb
	import alt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// arbitrary value, not any real maker
	localparam logic [15:0] MAKER = 16'h1A2B;
	logic              clk, rst, rng, lat, diag;
	logic [7:0]        addr;
	logic              wr, rd, sv, bv, tv, pv, alert;
	logic [15:0]       wdata, rdata, sh, bu;
	logic [11:0]       te;
	logic [23:0]       pw;
	logic [5:0]        flags;
	int                errors, checks;
	logic [15:0]       thr [6];
	logic [15:0]       msk [6] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF,
		16'hFFF0, 16'hFFFF};
	logic [15:0]       rst_v [6] = '{SHUNT_HI_RST, SHUNT_LO_RST, BUS_HI_RST,
		BUS_LO_RST, TEMP_HI_RST, POWER_HI_RST};
	logic [15:0]       calm [6] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000,
		16'h7FF0, 16'hFFFF};

	alt_limits #(.MAKER_CODE(MAKER)) dut (.clk(clk), .rst(rst),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
		.reg_rdata(rdata), .shunt_range_select(rng),
		.alert_latch_select(lat), .diag_read(diag), .shunt_result(sh),
		.shunt_valid(sv), .bus_result(bu), .bus_valid(bv),
		.die_temperature_result(te), .temp_valid(tv), .power_result(pw),
		.power_valid(pv), .limit_flags(flags), .limit_alert(alert));

	alt_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [5:0] model();
		logic [5:0] f;
		f[FLG_TEMP_HI] = int'($signed(te)) > int'($signed(thr[4][15:4]));
		f[FLG_SHUNT_HI] = int'($signed(sh)) > int'($signed(thr[0]));
		f[FLG_SHUNT_LO] = int'($signed(sh)) < int'($signed(thr[1]));
		f[FLG_BUS_HI] = int'(bu) > int'(thr[2]);
		f[FLG_BUS_LO] = int'(bu) < int'(thr[3]);
		f[FLG_POWER_HI] = int'(pw) > int'(thr[5]) * 256;
		return f;
	endfunction

	task automatic wr_rd(input int i, input logic [15:0] v);
		logic [15:0] d;
		host.wr(SHUNT_HI_OFS + 8'(i), v);
		thr[i] = v & msk[i];
		host.rd(SHUNT_HI_OFS + 8'(i), d);
		chk(d, thr[i]);
	endtask

	// flip toggles range in the valid cycle, which must drop the shunt sample
	task automatic measure(input logic [15:0] s, input logic [15:0] b,
		input logic [11:0] t, input logic [23:0] p, input logic flip);
		logic [5:0] e;
		@(posedge clk);
		#1;
		sh = s;
		bu = b;
		te = t;
		pw = p;
		{sv, bv, tv, pv} = 4'hF;
		rng = rng ^ flip;
		@(posedge clk);
		#1;
		{sv, bv, tv, pv} = 4'h0;
		repeat (3) @(posedge clk);
		#1;
		e = model();
		if (flip) begin
			e[FLG_SHUNT_HI] = 1'b0;
			e[FLG_SHUNT_LO] = 1'b0;
		end
		if (!lat) begin
			chk(16'(flags), 16'(e));
			chk(16'(alert), 16'(|e));
		end
	endtask

	task automatic pulse_diag();
		@(posedge clk);
		#1;
		diag = 1'b1;
		@(posedge clk);
		#1;
		diag = 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100_000;
		errors++;
		print_verdict();
	end

	initial begin
		logic [15:0] d;
		logic [15:0] v [6];
		void'($urandom(32'h25F9));
		rst = 1'b1;
		{rng, lat, diag, sv, bv, tv, pv} = '0;
		{sh, bu, te, pw} = '0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			thr[i] = rst_v[i] & msk[i];
			host.rd(SHUNT_HI_OFS + 8'(i), d);
			chk(d, thr[i]);
		end
		host.wr(MAKER_OFS, 16'h0000);
		host.rd(MAKER_OFS, d);
		chk(d, MAKER);
		host.rd(8'h00, d);
		chk(d, 16'h0000);
		for (int n = 0; n < 16; n++) begin
			for (int i = 0; i < 6; i++) begin
				v[i] = 16'($urandom);
			end
			if ($signed(v[0]) < $signed(v[1])) begin
				d = v[0];
				v[0] = v[1];
				v[1] = d;
			end
			for (int i = 0; i < 6; i++) begin
				wr_rd(i, v[i]);
			end
			@(posedge clk);
			#1;
			rng = 1'($urandom);
			measure(16'($urandom), 16'($urandom), 12'($urandom),
				24'($urandom), 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			wr_rd(i, calm[i]);
		end
		measure(16'h0000, 16'h0001, 12'h000, 24'h0, 1'b0);
		measure(16'h0000, 16'h0001, 12'h000, 24'h0, 1'b1);
		measure(16'h0000, 16'h0001, 12'h000, 24'h0, 1'b0);
		lat = 1'b1;
		pulse_diag();
		chk(16'(flags), 16'h0010);
		measure(16'h8001, 16'h0001, 12'h000, 24'h0, 1'b0);
		chk(16'(flags), 16'h0010);
		chk(16'(alert), 16'h0001);
		pulse_diag();
		chk(16'(flags), 16'h0000);
		@(posedge clk);
		#1;
		chk(16'(alert), 16'h0000);
		print_verdict();
	end
endmodule // alt_limits_tb
